// *** rtl/qdsc_decoder.v ***
// serial command decoder for a quad 16-bit dac: shift register, decode and channel registers
//
// Contract
// RL1 - 24-bit word, msb is read/write flag
// RL2 - bits 21..19 select target register
// RL3 - bits 18..16 select channel, 100 all
// RL4 - function register uses channel field as operation
// RL5 - nop changes nothing, enables readback
// RL6 - control bit 5 enables ground offset adjust
// RL7 - bits 4 and 2 set aux directions
// RL8 - output aux pins drive last value bit
// RL9 - input aux pins read back live level
// RL10 - value writes ignored while pin is input
// RL11 - control bit 0 disables readback output
// RL12 - clear sets all channels to zero code
// RL13 - load copies input values to dac registers
// RL14 - data access carries 16-bit code
// RL15 - coarse gain two bits, default 00
// RL16 - fine gain six bits twos complement
// RL17 - offset eight bits twos complement
// RL18 - host sends zero in bit 22
// RL19 - unlisted selector or function codes ignored
`include "qdsc_consts.vh"
`default_nettype none
module qdsc_decoder (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        sclk,
   input  wire        sync_n,
   input  wire        sdin,
   input  wire [1:0]  aux_in,
   output wire        sdo_out,
   output wire        sdo_oe_n,
   output wire [1:0]  aux_out,
   output wire [1:0]  aux_oe_n,
   output wire [63:0] input_code_flat,
   output wire [63:0] dac_code_flat,
   output wire [7:0]  coarse_flat,
   output wire [23:0] fine_flat,
   output wire [31:0] offset_flat,
   output wire        ground_adj_en,
   output reg         cmd_done
);
   wire [4:0]  pins_s;
   wire        sclk_s;
   wire        sync_s;
   wire        sdin_s;
   wire [1:0]  aux_s;
   reg         sclk_d_reg;
   reg         sync_d_reg;
   reg  [23:0] shift_reg;
   reg  [4:0]  cnt_reg;
   reg  [23:0] rb_reg;
   reg  [23:0] rb_next;
   reg  [5:0]  ctl_reg;
   reg  [15:0] in_reg     [0:3];
   reg  [15:0] dac_reg    [0:3];
   reg  [1:0]  coarse_reg [0:3];
   reg  [5:0]  fine_reg   [0:3];
   reg  [7:0]  offset_reg [0:3];
   reg  [5:0]  ctl_view;
   wire        sclk_fall;
   wire        sclk_rise;
   wire        frame;
   wire        frame_start;
   wire        frame_end;
   wire        exec;
   wire        is_read;
   wire [2:0]  sel;
   wire [2:0]  ch;
   wire [15:0] word_data;
   wire        sel_ok;
   wire        ch_ok;
   wire        fn_ok;
   wire        dir1_new;
   wire        dir0_new;
   integer     i;

   // true when channel index idx is addressed by field c
   function chan_hit;
      input [2:0] c;
      input [1:0] idx;
      begin
         chan_hit = (c == `QDSC_CH_ALL) || (c == {1'b0, idx});
      end
   endfunction

   qdsc_sync #(
      .W   (5),
      .RST (5'h18)
   ) u_sync (
      .clk  (mclk),
      .rstn (rstn),
      .d    ({sclk, sync_n, sdin, aux_in}),
      .q    (pins_s)
   );

   assign sclk_s      = pins_s[4];
   assign sync_s      = pins_s[3];
   assign sdin_s      = pins_s[2];
   assign aux_s       = pins_s[1:0];
   assign sclk_fall   = sclk_d_reg & ~sclk_s;
   assign sclk_rise   = ~sclk_d_reg & sclk_s;
   assign frame       = ~sync_s;
   assign frame_start = sync_d_reg & ~sync_s;
   assign frame_end   = ~sync_d_reg & sync_s;
   assign exec        = frame_end && (cnt_reg == `QDSC_WORD_BITS);                 // [RL1]

   assign is_read   = shift_reg[`QDSC_RW_BIT];                                     // [RL1]
   assign sel       = shift_reg[`QDSC_REG_HI:`QDSC_REG_LO];                        // [RL2]
   assign ch        = shift_reg[`QDSC_CH_HI:`QDSC_CH_LO];                          // [RL3]
   assign word_data = shift_reg[15:0];                                             // [RL14]
   // bit 22 is not checked; the host keeps it zero [RL18]
   assign ch_ok     = (ch <= `QDSC_CH_ALL);
   assign sel_ok    = (sel == `QDSC_SEL_FUNC) || (sel == `QDSC_SEL_DATA) || (sel == `QDSC_SEL_COARSE) ||
                      (sel == `QDSC_SEL_FINE) || (sel == `QDSC_SEL_OFFSET);        // [RL19]
   assign fn_ok     = (ch == `QDSC_FN_NOP) || (ch == `QDSC_FN_CTRL) ||
                      (ch == `QDSC_FN_CLEAR) || (ch == `QDSC_FN_LOAD);             // [RL19]
   assign dir1_new  = word_data[`QDSC_CTL_DIR1];
   assign dir0_new  = word_data[`QDSC_CTL_DIR0];

   // link sampling and serial shift
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sclk_d_reg <= 1'b1;
         sync_d_reg <= 1'b1;
         shift_reg  <= 24'h000000;
         cnt_reg    <= 5'h00;
      end
      else
      begin
         sclk_d_reg <= sclk_s;
         sync_d_reg <= sync_s;
         if (frame_start)
            cnt_reg <= 5'h00;
         else if (frame && sclk_fall)
         begin
            shift_reg <= {shift_reg[22:0], sdin_s};                                // [RL1]
            if (cnt_reg != 5'h1f)
               cnt_reg <= cnt_reg + 5'h01;
         end
      end
   end

   // control word as read back; input pins show their live level
   always @*
   begin
      ctl_view = ctl_reg;
      if (!ctl_reg[`QDSC_CTL_DIR1])
         ctl_view[`QDSC_CTL_VAL1] = aux_s[1];                                      // [RL9]
      if (!ctl_reg[`QDSC_CTL_DIR0])
         ctl_view[`QDSC_CTL_VAL0] = aux_s[0];                                      // [RL9]
   end

   // readback word for a read command
   always @*
   begin
      rb_next = {shift_reg[23:16], 16'h0000};
      if (ch != `QDSC_CH_ALL)
      begin
         case (sel)
            `QDSC_SEL_DATA:   rb_next[15:0] = in_reg[ch[1:0]];
            `QDSC_SEL_COARSE: rb_next[15:0] = {14'h0000, coarse_reg[ch[1:0]]};
            `QDSC_SEL_FINE:   rb_next[15:0] = {10'h000, fine_reg[ch[1:0]]};
            `QDSC_SEL_OFFSET: rb_next[15:0] = {8'h00, offset_reg[ch[1:0]]};
            default:          rb_next[15:0] = 16'h0000;
         endcase
      end
      if ((sel == `QDSC_SEL_FUNC) && (ch == `QDSC_FN_CTRL))
         rb_next[15:0] = {10'h000, ctl_view};
   end

   // readback shifter: loaded by a read, shifted out on rising sclk of the next frame
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rb_reg <= 24'h000000;
      else if (exec && is_read && sel_ok && ((sel == `QDSC_SEL_FUNC) ? fn_ok : ch_ok))   // [RL19]
         rb_reg <= rb_next;                                                        // [RL5]
      else if (frame && sclk_rise)
         rb_reg <= {rb_reg[22:0], 1'b0};
   end

   // command execution
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_reg  <= `QDSC_CTL_RST;
         cmd_done <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
         begin
            in_reg[i]     <= `QDSC_DATA_RST;
            dac_reg[i]    <= `QDSC_DATA_RST;
            coarse_reg[i] <= `QDSC_COARSE_RST;                                      // [RL15]
            fine_reg[i]   <= `QDSC_FINE_RST;                                        // [RL16]
            offset_reg[i] <= `QDSC_OFFSET_RST;                                      // [RL17]
         end
      end
      else
      begin
         cmd_done <= exec;
         if (exec && !is_read && sel_ok && ((sel == `QDSC_SEL_FUNC) ? fn_ok : ch_ok))  // [RL19]
         begin
            if (sel == `QDSC_SEL_FUNC)                                             // [RL4]
            begin
               case (ch)
                  `QDSC_FN_CTRL:
                  begin
                     ctl_reg[`QDSC_CTL_GND_ADJ] <= word_data[`QDSC_CTL_GND_ADJ];   // [RL6]
                     ctl_reg[`QDSC_CTL_DIR1]    <= dir1_new;                       // [RL7]
                     ctl_reg[`QDSC_CTL_DIR0]    <= dir0_new;                       // [RL7]
                     if (dir1_new)
                        ctl_reg[`QDSC_CTL_VAL1] <= word_data[`QDSC_CTL_VAL1];      // [RL10]
                     if (dir0_new)
                        ctl_reg[`QDSC_CTL_VAL0] <= word_data[`QDSC_CTL_VAL0];      // [RL10]
                     ctl_reg[`QDSC_CTL_SDO_DIS] <= word_data[`QDSC_CTL_SDO_DIS];   // [RL11]
                  end
                  `QDSC_FN_CLEAR:
                     for (i = 0; i < 4; i = i + 1)
                     begin
                        in_reg[i]  <= `QDSC_CLEAR_CODE;                            // [RL12]
                        dac_reg[i] <= `QDSC_CLEAR_CODE;                            // [RL12]
                     end
                  `QDSC_FN_LOAD:
                     for (i = 0; i < 4; i = i + 1)
                        dac_reg[i] <= in_reg[i];                                   // [RL13]
                  default: ;                                                       // [RL5] [RL19]
               endcase
            end
            else
            begin
               for (i = 0; i < 4; i = i + 1)
               begin
                  if (chan_hit(ch, i[1:0]))                                        // [RL3]
                  begin
                     case (sel)
                        `QDSC_SEL_DATA:   in_reg[i]     <= word_data;              // [RL14]
                        `QDSC_SEL_COARSE: coarse_reg[i] <= word_data[1:0];         // [RL15]
                        `QDSC_SEL_FINE:   fine_reg[i]   <= word_data[5:0];         // [RL16]
                        `QDSC_SEL_OFFSET: offset_reg[i] <= word_data[7:0];         // [RL17]
                        default: ;
                     endcase
                  end
               end
            end
         end
      end
   end

   assign sdo_out       = rb_reg[23];
   assign sdo_oe_n      = ctl_reg[`QDSC_CTL_SDO_DIS];                              // [RL11]
   assign aux_out       = {ctl_reg[`QDSC_CTL_VAL1], ctl_reg[`QDSC_CTL_VAL0]};      // [RL8]
   assign aux_oe_n      = {~ctl_reg[`QDSC_CTL_DIR1], ~ctl_reg[`QDSC_CTL_DIR0]};    // [RL7]
   assign ground_adj_en = ctl_reg[`QDSC_CTL_GND_ADJ];                              // [RL6]

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_flat
         assign input_code_flat[16*g+15:16*g] = in_reg[g];
         assign dac_code_flat[16*g+15:16*g]   = dac_reg[g];
         assign coarse_flat[2*g+1:2*g]        = coarse_reg[g];
         assign fine_flat[6*g+5:6*g]          = fine_reg[g];
         assign offset_flat[8*g+7:8*g]        = offset_reg[g];
      end
   endgenerate
endmodule
`default_nettype wire

// *** rtl/qdsc_consts.vh ***
// constants for the quad dac serial command decoder
`ifndef QDSC_CONSTS_VH
`define QDSC_CONSTS_VH

`define QDSC_WORD_BITS     5'd24
`define QDSC_RW_BIT        23
`define QDSC_REG_HI        21
`define QDSC_REG_LO        19
`define QDSC_CH_HI         18
`define QDSC_CH_LO         16

`define QDSC_SEL_FUNC      3'h0
`define QDSC_SEL_DATA      3'h2
`define QDSC_SEL_COARSE    3'h3
`define QDSC_SEL_FINE      3'h4
`define QDSC_SEL_OFFSET    3'h5

`define QDSC_CH_ALL        3'h4

`define QDSC_FN_NOP        3'h0
`define QDSC_FN_CTRL       3'h1
`define QDSC_FN_CLEAR      3'h4
`define QDSC_FN_LOAD       3'h5

`define QDSC_CTL_GND_ADJ   5
`define QDSC_CTL_DIR1      4
`define QDSC_CTL_VAL1      3
`define QDSC_CTL_DIR0      2
`define QDSC_CTL_VAL0      1
`define QDSC_CTL_SDO_DIS   0

`define QDSC_CLEAR_CODE    16'h0000
`define QDSC_DATA_RST      16'h0000
`define QDSC_COARSE_RST    2'h0
`define QDSC_FINE_RST      6'h00
`define QDSC_OFFSET_RST    8'h00
`define QDSC_CTL_RST       6'h00

`endif

// *** rtl/qdsc_sync.v ***
// two flip-flop synchroniser for pins entering the mclk domain
`default_nettype none
module qdsc_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input  wire         clk,
   input  wire         rstn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= RST;
         sync_reg <= RST;
      end
      else
      begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;
endmodule
`default_nettype wire

// *** bench/qdsc_host.sv ***
// serial master model driving the decoder link
`default_nettype none
module qdsc_host (
   output var logic sclk,
   output var logic sync_n,
   output var logic sdin,
   input  wire logic serial_readback_output
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sclk = 1'h1;
      sync_n = 1'h1;
      sdin = 1'h0;
   end
   // msb first, bit 22 sent as given, data moves while sclk high; clock idles high
   task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
      rd = 24'h0;
      sync_n = 1'h0;
      for (int i = 0; i < n; i++)
      begin
         sdin = w[23 - i];
         #62.5;
         rd = {rd[22:0], serial_readback_output};
         sclk = 1'h0;
         #62.5;
         sclk = 1'h1;
      end
      #62.5;
      sync_n = 1'h1;
      sdin = ~sdin;
   endtask
endmodule
`default_nettype wire

// *** bench/qdsc_decoder_assertions.sv ***
// concurrent checks on the decoder ports
`default_nettype none
module qdsc_checker (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        sclk,
   input wire logic        sync_n,
   input wire logic        sdin,
   input wire logic [1:0]  aux_in,
   input wire logic        sdo_out,
   input wire logic        sdo_oe_n,
   input wire logic [1:0]  aux_out,
   input wire logic [1:0]  aux_oe_n,
   input wire logic [63:0] input_code_flat,
   input wire logic [63:0] dac_code_flat,
   input wire logic [7:0]  coarse_flat,
   input wire logic [23:0] fine_flat,
   input wire logic [31:0] offset_flat,
   input wire logic        ground_adj_en,
   input wire logic        cmd_done
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_done_single: assert property (cmd_done |=> !cmd_done)
      else $error("completion pulse too long");
   a_done_framed: assert property (cmd_done |-> sync_n && $past(sync_n, 2))
      else $error("completion inside a frame");
   a_ctl_hold: assert property ($changed({aux_oe_n, aux_out, sdo_oe_n, ground_adj_en}) |-> cmd_done)
      else $error("control outputs moved without a command");
   a_input_hold: assert property ($changed(input_code_flat) |-> cmd_done)
      else $error("input code moved without a command");
   a_trim_hold: assert property ($changed({coarse_flat, fine_flat, offset_flat}) |-> cmd_done)
      else $error("trim moved without a command");
   a_dac_follow: assert property ($changed(dac_code_flat) |-> cmd_done && dac_code_flat == input_code_flat)
      else $error("dac code not taken from input code");
   a_aux_keep: assert property (((aux_out ^ $past(aux_out)) & aux_oe_n) == 2'h0)
      else $error("aux value changed on an input pin");
   a_sdo_shift: assert property ($changed(sdo_out) |-> cmd_done || $past(sclk, 2) || $past(sclk, 3))
      else $error("readback moved off a clock rise");
   cover property (cmd_done && aux_oe_n == 2'h0);
   cover property ($changed(dac_code_flat));
   cover property (sdo_oe_n);
endmodule
bind qdsc_decoder qdsc_checker i_qdsc_checker (.mclk(mclk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
   .aux_in(aux_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .aux_out(aux_out), .aux_oe_n(aux_oe_n),
   .input_code_flat(input_code_flat), .dac_code_flat(dac_code_flat), .coarse_flat(coarse_flat),
   .fine_flat(fine_flat), .offset_flat(offset_flat), .ground_adj_en(ground_adj_en), .cmd_done(cmd_done));
`default_nettype wire

// *** bench/qdsc_decoder_tb_top.sv ***
// testbench for the serial command decoder
`default_nettype none
module qdsc_decoder_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rstn, sclk, sync_n, sdin, sdo_out, sdo_oe_n, ground_adj_en, cmd_done;
   logic [1:0]  aux_in, aux_out, aux_oe_n;
   logic [63:0] input_code_flat, dac_code_flat;
   logic [7:0]  coarse_flat;
   logic [23:0] fine_flat, rd;
   logic [31:0] offset_flat;
   int          errors, total_checks, cyc;
   qdsc_decoder i_qdsc_decoder (.mclk(mclk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
      .aux_in(aux_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .aux_out(aux_out), .aux_oe_n(aux_oe_n),
      .input_code_flat(input_code_flat), .dac_code_flat(dac_code_flat), .coarse_flat(coarse_flat),
      .fine_flat(fine_flat), .offset_flat(offset_flat), .ground_adj_en(ground_adj_en), .cmd_done(cmd_done));
   // a released readback line shows the inverse of the last bit
   qdsc_host i_qdsc_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .serial_readback_output(sdo_out ^ sdo_oe_n));
   initial
   begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors = errors + 1;
         results();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one frame of n bits, then a bounded wait for the completion pulse
   task automatic cmd(input logic [23:0] w, input int n = 24);
      int k;
      i_qdsc_host.xfer(w, n, rd);
      k = 0;
      while (cmd_done !== 1'h1 && k < 12)
      begin
         @(negedge mclk);
         k++;
      end
      chk({63'h0, cmd_done}, {63'h0, n == 24});
      @(negedge mclk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      rstn = 1'h0;
      aux_in = 2'h1;
      repeat (4) @(negedge mclk);
      rstn = 1'h1;
      repeat (4) @(negedge mclk);
      chk({aux_oe_n, sdo_oe_n, ground_adj_en, aux_out, sdo_out}, 64'h60);
      chk({coarse_flat, fine_flat, offset_flat}, 64'h0);
      $display("test reset done");
      cmd(24'h111234);
      chk(input_code_flat, 64'h0000_0000_1234_0000);
      chk(dac_code_flat, 64'h0);
      cmd(24'h145a5a);
      chk(input_code_flat, {4{16'h5a5a}});
      cmd(24'h050000);
      chk(dac_code_flat, {4{16'h5a5a}});
      $display("test data done");
      cmd(24'h1a0002);
      cmd(24'h23002b);
      cmd(24'h2800f0);
      chk({coarse_flat, fine_flat, offset_flat}, 64'h20_ac0000_000000f0);
      cmd(24'h080000);
      cmd(24'h151111);
      cmd(24'h021111);
      cmd(24'h149999, 23);
      cmd(24'h00ffff);
      chk(input_code_flat ^ dac_code_flat, 64'h0);
      chk({coarse_flat, fine_flat, offset_flat}, 64'h20_ac0000_000000f0);
      $display("test ignore done");
      cmd(24'h01003c);
      chk({aux_oe_n, sdo_oe_n, ground_adj_en, aux_out}, 64'h06);
      cmd(24'h01000a);
      chk({aux_oe_n, sdo_oe_n, ground_adj_en, aux_out}, 64'h32);
      $display("test control done");
      cmd(24'h810000);
      cmd(24'h000000);
      chk(rd, 64'h810002);
      cmd(24'ha30000);
      cmd(24'h000000);
      chk(rd, 64'ha3002b);
      cmd(24'h010001);
      chk(sdo_oe_n, 64'h1);
      cmd(24'h010000);
      chk(sdo_oe_n, 64'h0);
      $display("test readback done");
      cmd(24'h040000);
      chk(input_code_flat | dac_code_flat, 64'h0);
      $display("test clear done");
      results();
   end
endmodule
`default_nettype wire
